// [readout_pkg.sv]
// Shared constants for the readout event builder control block.
// Assumes a 32-bit register port with byte offsets on an 8-bit address.
package readout_pkg;

	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 8;
	localparam int SRC_ID_W   = 8;
	localparam int LEN_W      = 16;
	localparam int SYNC_DEPTH = 512;
	localparam int OUT_DEPTH  = 8;
	localparam int SYNC_CNT_W = 10;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CONTROL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SOURCE_ID   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SYNC_DATA   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_SYNC_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SYNC_LEN    = 8'h14;

	////////////////////////////////////////////////////////////////////////////////
	// Control bits
	localparam int CTL_CORE_RESET = 0;
	localparam int CTL_PAUSE      = 1;
	localparam int CTL_USE_DDR    = 2;
	localparam int CTL_DMA_RUN    = 3;
	localparam int CTL_FPGA_BANK  = 8;
	localparam int CTL_CPU_SYNC   = 9;
	localparam int CTL_CPU_ASYNC  = 10;

	localparam logic [DATA_W-1:0]   CTL_MASK        = 32'h0000070F;
	localparam logic [DATA_W-1:0]   CONTROL_RESET   = 32'h00000000;
	localparam logic [SRC_ID_W-1:0] SOURCE_ID_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Status fields and record header flags
	localparam int STAT_BACKPRESSURE = 16;
	localparam int STAT_OUT_PENDING  = 17;
	localparam int SYNC_FULL_BIT     = 31;
	localparam int SYNC_LEN_PEND_BIT = 30;
	localparam int HDR_ASYNC         = 8;
	localparam int HDR_FPGA          = 9;
	localparam int HDR_SYNC          = 10;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_HEADER,
		ST_TRIG,
		ST_FPGA,
		ST_SYNC_WAIT,
		ST_SYNC,
		ST_ASYNC,
		ST_ACK
	} build_state_t;

endpackage : readout_pkg

// [stream_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and a synchronous clear.
// Assumes one clock; in_ready is low exactly while full, out_valid high while not empty.
`timescale 1ns/10ps
module stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic                       clr,
	input  wire logic                       in_valid,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            in_ready,
	output logic                            out_valid,
	output logic [WIDTH-1:0]                out_data,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wp_r;
	logic [PTR_W-1:0] wp_nxt;
	logic [PTR_W-1:0] rp_r;
	logic [PTR_W-1:0] rp_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != CNT_W'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign count     = cnt_r;

	always_comb begin
		push    = in_valid && in_ready;
		pop     = out_ready && out_valid;
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		if (push) begin
			wp_nxt = (wp_r == PTR_W'(DEPTH-1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == PTR_W'(DEPTH-1)) ? '0 : rp_r + 1'b1;
		end
		cnt_nxt = cnt_r + CNT_W'(push) - CNT_W'(pop);
		if (clr) begin
			wp_nxt  = '0;
			rp_nxt  = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage carries no reset; only the pointers and the count decide what is valid
	always_ff @(posedge mclk) begin
		if (ce && push && !clr) begin
			mem[wp_r] <= in_data;
		end
	end

endmodule : stream_fifo

// [readout_event_builder_ctrl.sv]
// Readout event builder control: register port, record builder and output path.
// Assumes all stream sources, the TCP engine and the DDR path run on mclk.
//
// Notes on behaviour
// R1: Control bit 0 high holds the whole builder in reset; low lets it run.
// R2: Control bit 1 high stops new blocks going out; low lets blocks flow.
// R3: Pause only takes effect between blocks; a started block always completes.
// R4: Control bit 2 high routes built blocks toward the DDR buffer path.
// R5: Control bit 2 low bypasses DDR; only internal and TCP buffers are used.
// R6: Control bit 3 is the active-low DDR DMA reset, driven out as is.
// R7: Software keeps bit 3 low whenever DDR buffering is off.
// R8: Control bit 8 requires and builds the trigger FPGA bank per event.
// R9: Control bit 9 requires and builds the processor per-event bank.
// R10: Control bit 10 inserts a pending sporadic bank at the next block boundary.
// R11: Source number lives in bits 7:0 of offset 4 and goes in every header.
// R12: Processor bank FIFO holds 512 words; software polls full before writing.
// R13: Output is held while the active sink reports backpressure.
// R14: Control bits and source number clear to zero on system reset.
`timescale 1ns/10ps
module readout_event_builder_ctrl #(
	parameter int SYNC_WORDS = readout_pkg::SYNC_DEPTH,
	parameter int OUT_WORDS  = readout_pkg::OUT_DEPTH
) (
	input  wire logic                                mclk,
	input  wire logic                                rst,
	input  wire logic                                ce,
	input  wire logic [readout_pkg::ADDR_W-1:0]      reg_addr,
	input  wire logic [readout_pkg::DATA_W-1:0]      reg_wdata,
	input  wire logic                                reg_wr,
	input  wire logic                                reg_rd,
	output logic      [readout_pkg::DATA_W-1:0]      reg_rdata,
	input  wire logic                                trig_valid,
	input  wire logic [readout_pkg::DATA_W-1:0]      trig_data,
	input  wire logic                                trig_last,
	output logic                                     trig_ready,
	output logic                                     trig_block_ack,
	input  wire logic                                fpga_valid,
	input  wire logic [readout_pkg::DATA_W-1:0]      fpga_data,
	input  wire logic                                fpga_last,
	output logic                                     fpga_ready,
	input  wire logic                                async_valid,
	input  wire logic [readout_pkg::DATA_W-1:0]      async_data,
	input  wire logic                                async_last,
	output logic                                     async_ready,
	output logic                                     out_valid,
	output logic      [readout_pkg::DATA_W-1:0]      out_data,
	output logic                                     out_last,
	output logic                                     route_to_ddr,
	output logic                                     ddr_dma_rst_n,
	input  wire logic                                network_backpressure,
	input  wire logic                                ddr_backpressure
);
	import readout_pkg::*;

	localparam int SCNT_W = $clog2(SYNC_WORDS+1);
	localparam int OCNT_W = $clog2(OUT_WORDS+1);

	logic [DATA_W-1:0]   ctrl_r;
	logic [DATA_W-1:0]   ctrl_nxt;
	logic [SRC_ID_W-1:0] readout_source_number_r;
	logic [SRC_ID_W-1:0] readout_source_number_nxt;
	logic [LEN_W-1:0]    sync_len_r;
	logic [LEN_W-1:0]    sync_len_nxt;
	logic                sync_len_pend_r;
	logic                sync_len_pend_nxt;
	logic [DATA_W-1:0]   rdata_r;
	logic [DATA_W-1:0]   rdata_nxt;
	logic                sync_push;
	logic                len_consume;

	logic                core_clr;
	logic                pause_on;
	logic                bp_eff;

	build_state_t        st_r;
	build_state_t        st_nxt;
	logic [LEN_W-1:0]    cnt_r;
	logic [LEN_W-1:0]    cnt_nxt;
	logic                async_blk_r;
	logic                async_blk_nxt;
	logic                fpga_sel_r;
	logic                fpga_sel_nxt;
	logic                sync_sel_r;
	logic                sync_sel_nxt;
	logic                ack_r;
	logic                ack_nxt;
	logic                push_v;
	logic [DATA_W-1:0]   push_d;
	logic                push_l;
	logic                sync_pop;

	logic                sync_in_ready;
	logic                sync_out_valid;
	logic [DATA_W-1:0]   sync_out_data;
	logic [SCNT_W-1:0]   sync_count;
	logic                ofifo_in_ready;
	logic                ofifo_out_valid;
	logic [DATA_W:0]     ofifo_out_data;
	logic                ofifo_out_ready;
	logic [OCNT_W-1:0]   ofifo_count;

	logic                net_valid_r;
	logic                net_valid_nxt;
	logic [DATA_W-1:0]   net_data_r;
	logic [DATA_W-1:0]   net_data_nxt;
	logic                net_last_r;
	logic                net_last_nxt;

	assign core_clr = ctrl_r[CTL_CORE_RESET];
	assign pause_on = ctrl_r[CTL_PAUSE];
	// DDR path when enabled, TCP engine otherwise
	assign bp_eff   = ctrl_r[CTL_USE_DDR] ? ddr_backpressure : network_backpressure; // see R4 R5

	////////////////////////////////////////////////////////////////////////////////
	// Register port
	always_comb begin
		ctrl_nxt                  = ctrl_r;
		readout_source_number_nxt = readout_source_number_r;
		sync_len_nxt              = sync_len_r;
		sync_len_pend_nxt         = sync_len_pend_r;
		rdata_nxt                 = '0;
		sync_push                 = 1'b0;
		if (len_consume || core_clr) begin
			sync_len_pend_nxt = 1'b0;
		end
		// A length write in the same cycle as the builder takes one wins
		if (reg_wr) begin
			case (reg_addr)
				OFF_CONTROL: begin
					ctrl_nxt = reg_wdata & CTL_MASK;
				end
				OFF_SOURCE_ID: begin
					readout_source_number_nxt = reg_wdata[SRC_ID_W-1:0]; // see R11
				end
				OFF_SYNC_DATA: begin
					sync_push = 1'b1; // see R12
				end
				OFF_SYNC_LEN: begin
					sync_len_nxt      = reg_wdata[LEN_W-1:0];
					sync_len_pend_nxt = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFF_CONTROL: begin
					rdata_nxt = ctrl_r;
				end
				OFF_SOURCE_ID: begin
					rdata_nxt[SRC_ID_W-1:0] = readout_source_number_r;
				end
				OFF_STATUS: begin
					rdata_nxt[3:0]               = st_r;
					rdata_nxt[STAT_BACKPRESSURE] = network_backpressure; // see R13
					rdata_nxt[STAT_OUT_PENDING]  = net_valid_r || (ofifo_count != '0);
				end
				OFF_SYNC_STATUS: begin
					rdata_nxt[SYNC_FULL_BIT]     = !sync_in_ready; // see R12
					rdata_nxt[SYNC_LEN_PEND_BIT] = sync_len_pend_r;
					rdata_nxt[SYNC_CNT_W-1:0]    = SYNC_CNT_W'(sync_count);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_r                  <= CONTROL_RESET; // see R14
			readout_source_number_r <= SOURCE_ID_RESET; // see R14
			sync_len_r              <= '0;
			sync_len_pend_r         <= 1'b0;
			rdata_r                 <= '0;
		end else if (ce) begin
			ctrl_r                  <= ctrl_nxt;
			readout_source_number_r <= readout_source_number_nxt;
			sync_len_r              <= sync_len_nxt;
			sync_len_pend_r         <= sync_len_pend_nxt;
			rdata_r                 <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Record builder
	always_comb begin
		st_nxt        = st_r;
		cnt_nxt       = cnt_r;
		async_blk_nxt = async_blk_r;
		fpga_sel_nxt  = fpga_sel_r;
		sync_sel_nxt  = sync_sel_r;
		ack_nxt       = 1'b0;
		push_v        = 1'b0;
		push_d        = '0;
		push_l        = 1'b0;
		trig_ready    = 1'b0;
		fpga_ready    = 1'b0;
		async_ready   = 1'b0;
		sync_pop      = 1'b0;
		len_consume   = 1'b0;
		case (st_r)
			ST_IDLE: begin
				// Bank choices are frozen per block so a mid-block write cannot tear it
				if (!pause_on) begin // see R2 R3
					fpga_sel_nxt = ctrl_r[CTL_FPGA_BANK]; // see R8
					sync_sel_nxt = ctrl_r[CTL_CPU_SYNC]; // see R9
					if (ctrl_r[CTL_CPU_ASYNC] && async_valid) begin // see R10
						async_blk_nxt = 1'b1;
						st_nxt        = ST_HEADER;
					end else if (trig_valid) begin
						async_blk_nxt = 1'b0;
						st_nxt        = ST_HEADER;
					end
				end
			end
			ST_HEADER: begin
				push_v                   = 1'b1;
				push_d[SRC_ID_W-1:0]     = readout_source_number_r; // see R11
				push_d[HDR_ASYNC]        = async_blk_r;
				push_d[HDR_FPGA]         = fpga_sel_r && !async_blk_r;
				push_d[HDR_SYNC]         = sync_sel_r && !async_blk_r;
				if (ofifo_in_ready) begin
					st_nxt = async_blk_r ? ST_ASYNC : ST_TRIG;
				end
			end
			ST_TRIG: begin
				push_v     = trig_valid;
				push_d     = trig_data;
				push_l     = trig_last && !fpga_sel_r && !sync_sel_r;
				trig_ready = ofifo_in_ready;
				if (trig_valid && ofifo_in_ready && trig_last) begin
					st_nxt = fpga_sel_r ? ST_FPGA : (sync_sel_r ? ST_SYNC_WAIT : ST_ACK);
				end
			end
			ST_FPGA: begin
				push_v     = fpga_valid; // see R8
				push_d     = fpga_data;
				push_l     = fpga_last && !sync_sel_r;
				fpga_ready = ofifo_in_ready;
				if (fpga_valid && ofifo_in_ready && fpga_last) begin
					st_nxt = sync_sel_r ? ST_SYNC_WAIT : ST_ACK;
				end
			end
			ST_SYNC_WAIT: begin
				// The bank is required, so the block waits for software to post a length
				if (sync_len_pend_r) begin // see R9
					cnt_nxt     = sync_len_r;
					len_consume = 1'b1;
					st_nxt      = (sync_len_r == '0) ? ST_ACK : ST_SYNC;
				end
			end
			ST_SYNC: begin
				push_v   = sync_out_valid;
				push_d   = sync_out_data;
				push_l   = (cnt_r == LEN_W'(1));
				sync_pop = ofifo_in_ready;
				if (sync_out_valid && ofifo_in_ready) begin
					cnt_nxt = cnt_r - 1'b1;
					if (cnt_r == LEN_W'(1)) begin
						st_nxt = ST_ACK;
					end
				end
			end
			ST_ASYNC: begin
				push_v      = async_valid; // see R10
				push_d      = async_data;
				push_l      = async_last;
				async_ready = ofifo_in_ready;
				if (async_valid && ofifo_in_ready && async_last) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_ACK: begin
				ack_nxt = 1'b1;
				st_nxt  = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		if (core_clr) begin // see R1
			st_nxt      = ST_IDLE;
			cnt_nxt     = '0;
			ack_nxt     = 1'b0;
			push_v      = 1'b0;
			trig_ready  = 1'b0;
			fpga_ready  = 1'b0;
			async_ready = 1'b0;
			sync_pop    = 1'b0;
			len_consume = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r        <= ST_IDLE;
			cnt_r       <= '0;
			async_blk_r <= 1'b0;
			fpga_sel_r  <= 1'b0;
			sync_sel_r  <= 1'b0;
			ack_r       <= 1'b0;
		end else if (ce) begin
			st_r        <= st_nxt;
			cnt_r       <= cnt_nxt;
			async_blk_r <= async_blk_nxt;
			fpga_sel_r  <= fpga_sel_nxt;
			sync_sel_r  <= sync_sel_nxt;
			ack_r       <= ack_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Buffers: processor bank words and the built-record output queue
	stream_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (SYNC_WORDS)
	) u_sync_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.clr       (core_clr),
		.in_valid  (sync_push),
		.in_data   (reg_wdata),
		.in_ready  (sync_in_ready),
		.out_valid (sync_out_valid),
		.out_data  (sync_out_data),
		.out_ready (sync_pop),
		.count     (sync_count)
	);

	stream_fifo #(
		.WIDTH (DATA_W+1),
		.DEPTH (OUT_WORDS)
	) u_out_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.clr       (core_clr),
		.in_valid  (push_v),
		.in_data   ({push_l, push_d}),
		.in_ready  (ofifo_in_ready),
		.out_valid (ofifo_out_valid),
		.out_data  (ofifo_out_data),
		.out_ready (ofifo_out_ready),
		.count     (ofifo_count)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output register: a word stands until a cycle without backpressure takes it
	always_comb begin
		ofifo_out_ready = !net_valid_r || !bp_eff; // see R13
		net_valid_nxt   = net_valid_r;
		net_data_nxt    = net_data_r;
		net_last_nxt    = net_last_r;
		if (ofifo_out_ready) begin
			net_valid_nxt = ofifo_out_valid;
			net_data_nxt  = ofifo_out_data[DATA_W-1:0];
			net_last_nxt  = ofifo_out_data[DATA_W];
		end
		if (core_clr) begin // see R1
			net_valid_nxt = 1'b0;
			net_last_nxt  = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			net_valid_r <= 1'b0;
			net_data_r  <= '0;
			net_last_r  <= 1'b0;
		end else if (ce) begin
			net_valid_r <= net_valid_nxt;
			net_data_r  <= net_data_nxt;
			net_last_r  <= net_last_nxt;
		end
	end

	assign reg_rdata      = rdata_r;
	assign trig_block_ack = ack_r;
	assign out_valid      = net_valid_r;
	assign out_data       = net_data_r;
	assign out_last       = net_last_r;
	assign route_to_ddr   = ctrl_r[CTL_USE_DDR]; // see R4 R5
	assign ddr_dma_rst_n  = ctrl_r[CTL_DMA_RUN]; // see R6

endmodule : readout_event_builder_ctrl

// [readout_event_builder_ctrl_props.sv]
// Checker for the readout builder control ports.
// Assumes ce held high and bank enables changed only between records.
`timescale 1ns/10ps
module readout_event_builder_ctrl_props
	import readout_pkg::*;
(
	input wire logic                             mclk,
	input wire logic                             rst,
	input wire logic [readout_pkg::ADDR_W-1:0]   reg_addr,
	input wire logic [readout_pkg::DATA_W-1:0]   reg_wdata,
	input wire logic                             reg_wr,
	input wire logic                             reg_rd,
	input wire logic [readout_pkg::DATA_W-1:0]   reg_rdata,
	input wire logic                             trig_valid,
	input wire logic                             trig_ready,
	input wire logic                             trig_block_ack,
	input wire logic                             fpga_ready,
	input wire logic                             async_ready,
	input wire logic                             out_valid,
	input wire logic [readout_pkg::DATA_W-1:0]   out_data,
	input wire logic                             out_last,
	input wire logic                             route_to_ddr,
	input wire logic                             ddr_dma_rst_n,
	input wire logic                             network_backpressure,
	input wire logic                             ddr_backpressure
);
	logic [DATA_W-1:0]   ctl_r;
	logic [SRC_ID_W-1:0] src_r;
	logic                open_r, first_r, fpga_en_r;
	wire wr_ctl = reg_wr && reg_addr == OFF_CONTROL;
	wire bp     = route_to_ddr ? ddr_backpressure : network_backpressure;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctl_r     <= '0;
			src_r     <= '0;
			open_r    <= 1'b0;
			first_r   <= 1'b1;
			fpga_en_r <= 1'b0;
		end else begin
			if (wr_ctl)
				ctl_r <= reg_wdata & CTL_MASK;
			if (reg_wr && reg_addr == OFF_SOURCE_ID)
				src_r <= reg_wdata[SRC_ID_W-1:0];
			if (ctl_r[CTL_CORE_RESET] || trig_block_ack)
				open_r <= 1'b0;
			else if (trig_valid && trig_ready)
				open_r <= 1'b1;
			if (!open_r && trig_valid && trig_ready)
				fpga_en_r <= ctl_r[CTL_FPGA_BANK];
			if (ctl_r[CTL_CORE_RESET])
				first_r <= 1'b1;
			else if (out_valid && !bp)
				first_r <= out_last;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_wr_ctl;
		wr_ctl;
	endsequence
	sequence s_rd_ctl;
		reg_rd && reg_addr == OFF_CONTROL && !reg_wr;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_ctrl_read_back: assert property (s_wr_ctl ##2 s_rd_ctl |=>
		reg_rdata == ($past(reg_wdata, 3) & CTL_MASK)) else $error("control readback wrong");
	a_route_on_write: assert property ($changed(route_to_ddr) |->
		$past(wr_ctl) || $past(wr_ctl, 2)) else $error("route changed without write");
	a_dma_on_write: assert property ($changed(ddr_dma_rst_n) |->
		$past(wr_ctl) || $past(wr_ctl, 2)) else $error("dma reset changed alone");
	a_soft_reset_quiet: assert property (ctl_r[0] && $past(ctl_r[0]) |->
		!trig_ready && !fpga_ready && !async_ready && !out_valid) else $error("busy in reset");
	a_pause_no_start: assert property ($rose(trig_ready) && !open_r |->
		!($past(ctl_r[1]) && $past(ctl_r[1], 2) && $past(ctl_r[1], 3)))
		else $error("block started while paused");
	a_ack_single: assert property (trig_block_ack |-> open_r ##1 !trig_block_ack)
		else $error("stray or long ack");
	a_fpga_gated: assert property (fpga_ready |-> open_r && fpga_en_r)
		else $error("fpga bank read while off");
	a_async_gated: assert property (async_ready |-> ctl_r[CTL_CPU_ASYNC])
		else $error("sporadic bank read while off");
	a_header_source: assert property (out_valid && first_r && !ctl_r[0] |->
		out_data[SRC_ID_W-1:0] == src_r) else $error("header source number wrong");
	a_hold_on_busy: assert property (out_valid && bp && !ctl_r[0] |=>
		out_valid && $stable(out_data) && $stable(out_last)) else $error("output moved");
	a_reset_outputs: assert property ($past(rst) |-> !route_to_ddr &&
		!ddr_dma_rst_n && !out_valid && !trig_block_ack) else $error("outputs not cleared");
endmodule : readout_event_builder_ctrl_props

// [net_sink_model.sv]
// Sink model of the network event builder and the DDR path.
// Assumes one clock; refuses data at random while stall_en is high.
`timescale 1ns/10ps
module net_sink_model (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic stall_en,
	input  wire logic link_down,
	input  wire logic out_valid,
	input  wire logic route_to_ddr,
	output logic      network_backpressure,
	output logic      ddr_backpressure,
	output logic      take
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			network_backpressure <= 1'b0;
			ddr_backpressure     <= 1'b0;
		end else begin
			// A dropped link refuses as hard as a full engine buffer
			network_backpressure <= link_down | (stall_en & 1'($urandom_range(1)));
			ddr_backpressure     <= link_down | (stall_en & 1'($urandom_range(1)));
		end
	end
	assign take = out_valid & ~(route_to_ddr ? ddr_backpressure : network_backpressure);
endmodule : net_sink_model

// [test_readout_event_builder_ctrl.sv]
// Self-checking bench for the readout builder control block.
// Assumes the sink model drives backpressure; ce is held high.
`timescale 1ns/10ps
module test_readout_event_builder_ctrl;
	import readout_pkg::*;
	logic              mclk, rst, reg_wr, reg_rd, stall_en, link_down;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, ctl, d;
	logic [2:0]        s_valid, s_last;
	logic [DATA_W-1:0] s_data [3];
	wire  [2:0]        s_ready;
	wire  [DATA_W-1:0] reg_rdata, out_data;
	wire               out_valid, out_last, route_to_ddr, ddr_dma_rst_n, ack, nbp, dbp, take;
	logic [32:0]       exp_q [$];
	logic [7:0]        src;
	logic [31:0]       cv [3] = '{32'hFFFFFFF0, 32'h0000000C, 32'h00000000};
	int                errors, tests_run, cyc, rx;

	readout_event_builder_ctrl dut (.mclk, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .trig_valid(s_valid[0]), .trig_data(s_data[0]),
		.trig_last(s_last[0]), .trig_ready(s_ready[0]), .trig_block_ack(ack),
		.fpga_valid(s_valid[1]), .fpga_data(s_data[1]), .fpga_last(s_last[1]),
		.fpga_ready(s_ready[1]), .async_valid(s_valid[2]), .async_data(s_data[2]),
		.async_last(s_last[2]), .async_ready(s_ready[2]), .out_valid, .out_data, .out_last,
		.route_to_ddr, .ddr_dma_rst_n, .network_backpressure(nbp), .ddr_backpressure(dbp));
	net_sink_model sink (.mclk, .rst, .stall_en, .link_down, .out_valid, .route_to_ddr,
		.network_backpressure(nbp), .ddr_backpressure(dbp), .take);

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [32:0] got, input logic [32:0] want);
		tests_run++;
		if (got !== want) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
	endtask : rd

	task automatic setc(input logic [31:0] v);
		ctl = v;
		wr(OFF_CONTROL, v);
	endtask : setc

	task automatic send(input int k, input logic [31:0] w[$]);
		foreach (w[i]) begin
			s_valid[k] <= 1'b1;
			s_data[k]  <= w[i];
			s_last[k]  <= (i == w.size() - 1);
			do @(negedge mclk); while (!s_ready[k]);
			@(posedge mclk);
		end
		s_valid[k] <= 1'b0;
	endtask : send

	// pm: 1 pause mid-block, 2 held pause, 3 dead link, 4 sporadic record
	task automatic rec(input int nt, input int nf, input int ns, input int pm);
		logic [31:0] t[$], f[$], s[$];
		logic        a;
		int          r0, n;
		a = (pm == 4);
		exp_q.push_back({22'h0, ctl[9] & !a, ctl[8] & !a, a, src});
		repeat (nt) t.push_back($urandom);
		repeat (nf) f.push_back($urandom);
		repeat (ns) s.push_back($urandom);
		foreach (t[i]) exp_q.push_back({1'b0, t[i]});
		if (ctl[CTL_FPGA_BANK]) foreach (f[i]) exp_q.push_back({1'b0, f[i]});
		if (ctl[CTL_CPU_SYNC]) begin
			foreach (s[i]) begin
				exp_q.push_back({1'b0, s[i]});
				wr(OFF_SYNC_DATA, s[i]);
			end
			rd(OFF_SYNC_STATUS, d);
			check({1'b0, d}, {23'h0, 10'(ns)});
			wr(OFF_SYNC_LEN, ns);
		end
		exp_q[exp_q.size() - 1][32] = 1'b1;
		r0 = rx;
		@(posedge mclk);
		fork
			send(a ? 2 : 0, t);
			if (ctl[CTL_FPGA_BANK]) send(1, f);
			begin
				if (pm == 1) begin
					repeat (3) @(posedge mclk);
					setc(ctl | 32'h2);
				end
				if (pm == 2 || pm == 3) begin
					repeat (pm * 20) @(negedge mclk);
					check(33'(rx - r0), 33'h0);
					check({32'h0, s_ready[0]}, 33'h0);
					if (pm == 3) begin
						rd(OFF_STATUS, d);
						check({32'h0, d[16]}, 33'h1);
					end
					if (pm == 2) setc(ctl & ~32'h2);
					@(posedge mclk);
					link_down <= 1'b0;
				end
			end
		join
		n = 0;
		if (!a) begin
			do @(negedge mclk); while (!ack && ++n < 200);
			check({32'h0, ack}, 33'h1);
		end
		while (exp_q.size() != 0 && n < 800) begin
			@(negedge mclk);
			n++;
		end
		check(33'(exp_q.size()), 33'h0);
	endtask : rec

	always @(posedge mclk) begin
		if (!rst && take) begin
			rx++;
			if (exp_q.size() == 0)
				exp_q.push_back('1);
			check({out_last, out_data}, exp_q.pop_front());
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, stall_en, link_down, s_valid, s_last} = '0;
		s_data = '{default: '0};
		reg_addr = '0;
		reg_wdata = '0;
		ctl = '0;
		void'($urandom(28944));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(OFF_CONTROL, d);
		check({1'b0, d}, {1'b0, CONTROL_RESET});
		check({32'h0, ddr_dma_rst_n}, 33'h0);
		rd(OFF_SOURCE_ID, d);
		check({1'b0, d}, 33'h0);
		rd(8'h40, d);
		check({1'b0, d}, 33'h0);
		// Bit 3 only ever set alongside bit 2, so the DMA never runs unused
		foreach (cv[i]) begin
			setc(cv[i]);
			rd(OFF_CONTROL, d);
			check({1'b0, d}, {1'b0, ctl & CTL_MASK});
			check({32'h0, route_to_ddr}, {32'h0, ctl[2]});
			check({32'h0, ddr_dma_rst_n}, {32'h0, ctl[3]});
		end
		d = $urandom;
		src = d[7:0];
		wr(OFF_SOURCE_ID, d);
		rd(OFF_SOURCE_ID, d);
		check({1'b0, d}, {25'h0, src});
		setc(32'h1);
		s_valid[0] <= 1'b1;
		repeat (4) @(negedge mclk);
		check({31'h0, s_ready[0], out_valid}, 33'h0);
		@(posedge mclk);
		s_valid[0] <= 1'b0;
		setc(32'h0);
		stall_en <= 1'b1;
		rec(3, 2, 0, 0);
		setc(32'h100);
		rec(2, 3, 0, 1);
		rec(1, 2, 0, 2);
		setc(32'h300);
		rec(2, 1, 3, 0);
		setc(32'h20C);
		rec(4, 0, 2, 0);
		setc(32'h0);
		link_down <= 1'b1;
		rec(14, 0, 0, 3);
		setc(32'h400);
		rec(5, 0, 0, 4);
		tally_and_finish();
	end
endmodule : test_readout_event_builder_ctrl

bind readout_event_builder_ctrl readout_event_builder_ctrl_props chk (.mclk, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig_valid, .trig_ready, .trig_block_ack,
	.fpga_ready, .async_ready, .out_valid, .out_data, .out_last, .route_to_ddr,
	.ddr_dma_rst_n, .network_backpressure, .ddr_backpressure);
